// [core/hsdg_ctrl.sv]
// Headset detect and general pin control top level.
// Assumes synchronous sense and pin inputs and a simple register port.
// Behaviour
// - Detection runs only while the detect enable bit is one; off at reset.
// - Two-bit read-only headset kind: none, stereo, cellular, both.
// - Read-only presence flag is one while a headset is detected.
// - Read-only button flag is one while a button press is detected.
// - Headset debounce 16/32/64/128 ms at 2/4/8/16 ms ticks; reset 01.
// - Button debounce off, or 8/16/32 ms at 1/2/4 ms ticks.
// - Pin B carries detect interrupt when enabled and not general I/O.
// - Pin A carries detect interrupt when enabled and not general I/O.
// - Pin B forwarded clock is 256 times the faster sample rate.
// - Clock forwarding needs PLL on, no general I/O, no interrupt.
// - Pin A function: 0X tri-state, 10 button interrupt, 11 ADC word select.
// - ADC word select used only for differing rates; word clock frames DAC.
// - Pin B general output drives its output level bit.
// - Pin B general input level shows in a read-only flag.
// - Pin A general output drives its output level bit.
// - Pin A general input level shows in a read-only flag.
// - Reserved pin control bits read zero; software writes zero.
`timescale 1ns/1ps
module hsdg_ctrl #(
    parameter int TICK_CYCLES = hsdg_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Jack sense inputs
    input  wire logic        sense_stereo,
    input  wire logic        sense_cellular,
    input  wire logic        sense_button,
    // Clock sources from PLL and serial port
    input  wire logic        pll_enabled,
    input  wire logic        fwd_clk_play,     // 256 x playback rate
    input  wire logic        fwd_clk_rec,      // 256 x record rate
    input  wire logic        play_rate_faster,
    input  wire logic        adc_word_select,
    // Serial port framing control
    output logic             split_word_select,
    // General pin A
    input  wire logic        general_pin_a_i,
    output logic             general_pin_a_o,
    output logic             general_pin_a_oe,
    // General pin B
    input  wire logic        general_pin_b_i,
    output logic             general_pin_b_o,
    output logic             general_pin_b_oe
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        det_en;
        logic [1:0]  hs_deb;
        logic [1:0]  btn_deb;
        logic        b_irq_en;
        logic        a_irq_en;
        logic        b_clk_en;
        logic [1:0]  a_func;
        logic        b_out_en;
        logic        b_out_lvl;
        logic        b_in_en;
        logic        b_in_lvl;
        logic        a_out_en;
        logic        a_out_lvl;
        logic        a_in_en;
        logic        a_in_lvl;
        logic [15:0] rdata;
        logic        a_o;
        logic        a_oe;
        logic        b_o;
        logic        b_oe;
        logic        split_ws;
    } hsdg_ctrl_s;

    hsdg_ctrl_s st_reg;
    hsdg_ctrl_s st_next;

    logic       ms_tick;
    logic [1:0] kind;
    logic       button;
    logic       present;
    logic       detect_irq;
    logic       a_gpio;
    logic       b_gpio;
    logic       fwd_clk;
    logic [2:0] hs_shift;
    logic [2:0] btn_shift;
    logic [15:0] func_word;
    logic [15:0] pin_word;

    // ------------------------------------------------------------------
    // Debounce filters
    // ------------------------------------------------------------------
    hsdg_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk     (clk),
        .nrst    (nrst),
        .ms_tick (ms_tick)
    );

    // Headset tick 2 ms shifted by setting; button tick 1 ms shifted
    assign hs_shift  = {1'b0, st_reg.hs_deb} + 3'h1;
    assign btn_shift = {1'b0, st_reg.btn_deb} - 3'h1;

    hsdg_debounce #(
        .W (2)
    ) u_hs_deb (
        .clk     (clk),
        .nrst    (nrst),
        .ms_tick (ms_tick),
        .shift   (hs_shift),
        .bypass  (1'b0),
        .enable  (st_reg.det_en),
        .din     ({sense_cellular, sense_stereo}),
        .dout    (kind)
    );

    hsdg_debounce #(
        .W (1)
    ) u_btn_deb (
        .clk     (clk),
        .nrst    (nrst),
        .ms_tick (ms_tick),
        .shift   (btn_shift),
        .bypass  (st_reg.btn_deb == 2'h0),
        .enable  (st_reg.det_en),
        .din     (sense_button),
        .dout    (button)
    );

    // ------------------------------------------------------------------
    // Pin function resolution
    // ------------------------------------------------------------------
    assign present    = kind != 2'h0;
    assign detect_irq = present;
    assign a_gpio     = st_reg.a_out_en || st_reg.a_in_en;
    assign b_gpio     = st_reg.b_out_en || st_reg.b_in_en;
    assign fwd_clk    = play_rate_faster ? fwd_clk_play : fwd_clk_rec;

    // Read words; reserved bits zero
    always_comb begin
        func_word = '0;
        func_word[hsdg_pkg::DET_EN_BIT]                        = st_reg.det_en;
        func_word[hsdg_pkg::KIND_LSB +: 2]                     = kind;
        func_word[hsdg_pkg::PRESENT_BIT]                       = present;
        func_word[hsdg_pkg::BUTTON_BIT]                        = button;
        func_word[hsdg_pkg::HS_DEB_LSB +: 2]                   = st_reg.hs_deb;
        func_word[hsdg_pkg::BTN_DEB_LSB +: 2]                  = st_reg.btn_deb;
        func_word[hsdg_pkg::PIN_B_IRQ_BIT]                     = st_reg.b_irq_en;
        func_word[hsdg_pkg::PIN_A_IRQ_BIT]                     = st_reg.a_irq_en;
        func_word[hsdg_pkg::PIN_B_CLK_BIT]                     = st_reg.b_clk_en;
        func_word[hsdg_pkg::PIN_A_FUNC_LSB +: 2]               = st_reg.a_func;
        pin_word = '0;
        pin_word[hsdg_pkg::PIN_B_OUT_EN_BIT]  = st_reg.b_out_en;
        pin_word[hsdg_pkg::PIN_B_OUT_LVL_BIT] = st_reg.b_out_lvl;
        pin_word[hsdg_pkg::PIN_B_IN_EN_BIT]   = st_reg.b_in_en;
        pin_word[hsdg_pkg::PIN_B_IN_LVL_BIT]  = st_reg.b_in_lvl;
        pin_word[hsdg_pkg::PIN_A_OUT_EN_BIT]  = st_reg.a_out_en;
        pin_word[hsdg_pkg::PIN_A_OUT_LVL_BIT] = st_reg.a_out_lvl;
        pin_word[hsdg_pkg::PIN_A_IN_EN_BIT]   = st_reg.a_in_en;
        pin_word[hsdg_pkg::PIN_A_IN_LVL_BIT]  = st_reg.a_in_lvl;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Register writes
        if (reg_wr && reg_addr == hsdg_pkg::HEADSET_DETECT_PIN_FUNCTION_OFS) begin
            st_next.det_en   = reg_wdata[hsdg_pkg::DET_EN_BIT];
            st_next.hs_deb   = reg_wdata[hsdg_pkg::HS_DEB_LSB +: 2];
            st_next.btn_deb  = reg_wdata[hsdg_pkg::BTN_DEB_LSB +: 2];
            st_next.b_irq_en = reg_wdata[hsdg_pkg::PIN_B_IRQ_BIT];
            st_next.a_irq_en = reg_wdata[hsdg_pkg::PIN_A_IRQ_BIT];
            st_next.b_clk_en = reg_wdata[hsdg_pkg::PIN_B_CLK_BIT];
            st_next.a_func   = reg_wdata[hsdg_pkg::PIN_A_FUNC_LSB +: 2];
        end
        if (reg_wr && reg_addr == hsdg_pkg::GENERAL_PIN_CONTROL_OFS) begin
            st_next.b_out_en  = reg_wdata[hsdg_pkg::PIN_B_OUT_EN_BIT];
            st_next.b_out_lvl = reg_wdata[hsdg_pkg::PIN_B_OUT_LVL_BIT];
            st_next.b_in_en   = reg_wdata[hsdg_pkg::PIN_B_IN_EN_BIT];
            st_next.a_out_en  = reg_wdata[hsdg_pkg::PIN_A_OUT_EN_BIT];
            st_next.a_out_lvl = reg_wdata[hsdg_pkg::PIN_A_OUT_LVL_BIT];
            st_next.a_in_en   = reg_wdata[hsdg_pkg::PIN_A_IN_EN_BIT];
        end
        // Sample input levels while in input mode
        if (st_reg.b_in_en) begin
            st_next.b_in_lvl = general_pin_b_i;
        end
        if (st_reg.a_in_en) begin
            st_next.a_in_lvl = general_pin_a_i;
        end
        // Read data, registered; unmapped reads return zero
        if (reg_rd) begin
            st_next.rdata = 16'h0000;
            if (reg_addr == hsdg_pkg::HEADSET_DETECT_PIN_FUNCTION_OFS) begin
                st_next.rdata = func_word;
            end else if (reg_addr == hsdg_pkg::GENERAL_PIN_CONTROL_OFS) begin
                st_next.rdata = pin_word;
            end
        end
        // Pin A drive, general I/O first
        st_next.a_o  = 1'b0;
        st_next.a_oe = 1'b0;
        if (st_reg.a_out_en) begin
            st_next.a_o  = st_reg.a_out_lvl;
            st_next.a_oe = 1'b1;
        end else if (!st_reg.a_in_en) begin
            if (st_reg.a_irq_en) begin
                st_next.a_o  = detect_irq;
                st_next.a_oe = 1'b1;
            end else if (st_reg.a_func == hsdg_pkg::PIN_A_FUNC_BUTTON_IRQ) begin
                st_next.a_o  = button;
                st_next.a_oe = 1'b1;
            end else if (st_reg.a_func == hsdg_pkg::PIN_A_FUNC_ADC_WS) begin
                st_next.a_o  = adc_word_select;
                st_next.a_oe = 1'b1;
            end
        end
        st_next.split_ws = !a_gpio && !st_reg.a_irq_en &&
                           st_reg.a_func == hsdg_pkg::PIN_A_FUNC_ADC_WS;
        // Pin B drive, general I/O first
        st_next.b_o  = 1'b0;
        st_next.b_oe = 1'b0;
        if (st_reg.b_out_en) begin
            st_next.b_o  = st_reg.b_out_lvl;
            st_next.b_oe = 1'b1;
        end else if (!st_reg.b_in_en) begin
            if (st_reg.b_irq_en) begin
                st_next.b_o  = detect_irq;
                st_next.b_oe = 1'b1;
            end else if (st_reg.b_clk_en && pll_enabled) begin
                st_next.b_o  = fwd_clk;
                st_next.b_oe = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg         <= '0;
            st_reg.hs_deb  <= hsdg_pkg::HS_DEB_RESET;
            st_reg.btn_deb <= hsdg_pkg::BTN_DEB_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata         = st_reg.rdata;
    assign general_pin_a_o   = st_reg.a_o;
    assign general_pin_a_oe  = st_reg.a_oe;
    assign general_pin_b_o   = st_reg.b_o;
    assign general_pin_b_oe  = st_reg.b_oe;
    assign split_word_select = st_reg.split_ws;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_det_off_clear: assert property (@(posedge clk) disable iff (!nrst)
        !st_reg.det_en |-> ##2 (kind == 2'h0 && !button))
        else $error("detection flags set while detection disabled");

    a_kind_reads: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == hsdg_pkg::HEADSET_DETECT_PIN_FUNCTION_OFS
        |=> reg_rdata[14:13] == $past(kind))
        else $error("headset kind readback wrong");

    a_present_flag: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == hsdg_pkg::HEADSET_DETECT_PIN_FUNCTION_OFS
        |=> reg_rdata[12] == ($past(kind) != 2'h0))
        else $error("presence flag does not match kind");

    a_button_flag: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == hsdg_pkg::HEADSET_DETECT_PIN_FUNCTION_OFS
        |=> reg_rdata[11] == $past(button))
        else $error("button flag readback wrong");

    a_kind_stable: assert property (@(posedge clk) disable iff (!nrst)
        $changed(kind) && st_reg.det_en |-> $past(kind != {sense_cellular, sense_stereo}) &&
        $past({sense_cellular, sense_stereo}, 2) == $past({sense_cellular, sense_stereo}))
        else $error("kind changed without sense difference");

    a_btn_bypass: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.det_en && st_reg.btn_deb == 2'h0 ##1 st_reg.det_en && st_reg.btn_deb == 2'h0
        |-> button == $past(sense_button))
        else $error("button bypass not immediate");

    a_b_out_drive: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.b_out_en |=> general_pin_b_oe && general_pin_b_o == $past(st_reg.b_out_lvl))
        else $error("pin B output level wrong");

    a_a_out_drive: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.a_out_en |=> general_pin_a_oe && general_pin_a_o == $past(st_reg.a_out_lvl))
        else $error("pin A output level wrong");

    a_a_input_hiz: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.a_in_en && !st_reg.a_out_en |=> !general_pin_a_oe)
        else $error("pin A driven while general input");

    a_b_in_sample: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.b_in_en |=> st_reg.b_in_lvl == $past(general_pin_b_i))
        else $error("pin B input flag not sampled");

    a_pin_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == hsdg_pkg::GENERAL_PIN_CONTROL_OFS |=> reg_rdata[7:0] == 8'h00)
        else $error("reserved pin bits nonzero");

    a_clk_needs_pll: assert property (@(posedge clk) disable iff (!nrst)
        !pll_enabled && !st_reg.b_out_en && !st_reg.b_irq_en |=> !general_pin_b_oe)
        else $error("pin B driven without PLL");

    a_split_ws_drive: assert property (@(posedge clk) disable iff (!nrst)
        split_word_select |-> general_pin_a_oe && general_pin_a_o == $past(adc_word_select))
        else $error("ADC word select not on pin A");

    c_headset_seen: cover property (@(posedge clk) disable iff (!nrst) present);
    c_button_seen:  cover property (@(posedge clk) disable iff (!nrst) button);
    c_split_ws:     cover property (@(posedge clk) disable iff (!nrst) split_word_select);
    c_clk_forward:  cover property (@(posedge clk) disable iff (!nrst)
        st_reg.b_clk_en && pll_enabled && !b_gpio && !st_reg.b_irq_en);

endmodule : hsdg_ctrl

// [core/hsdg_debounce.sv]
// Debounce filter: output follows input after it is stable for eight ticks.
// Assumes ms_tick pulses once a millisecond; shift picks the tick resolution.
`timescale 1ns/1ps
module hsdg_debounce #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Timebase and setting
    input  wire logic         ms_tick,
    input  wire logic [2:0]   shift,     // Tick is 2**shift ms
    input  wire logic         bypass,
    input  wire logic         enable,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0]                  val;
        logic [W-1:0]                  last;
        logic [hsdg_pkg::MS_DIV_W-1:0] div;
        logic [3:0]                    ticks;
    } hsdg_deb_s;

    hsdg_deb_s st_reg;
    hsdg_deb_s st_next;
    logic      slow_tick;

    // Divide millisecond ticks down; a stale count after a setting change ends at once
    assign slow_tick = ms_tick &&
        (st_reg.div >= hsdg_pkg::MS_DIV_W'((32'h1 << shift) - 1));

    // Stability counter, restarted by every change of the input
    always_comb begin
        st_next = st_reg;
        st_next.last = din;
        if (ms_tick) begin
            st_next.div = slow_tick ? '0 : st_reg.div + 1'b1;
        end
        if (!enable) begin
            st_next = '0;
        end else if (bypass) begin
            st_next.val   = din;
            st_next.ticks = '0;
        end else if (din == st_reg.val) begin
            st_next.ticks = '0;
        end else if (din != st_reg.last) begin
            st_next.ticks = '0;
        end else if (slow_tick) begin
            if (st_reg.ticks == 4'(hsdg_pkg::DEB_TICKS - 1)) begin
                st_next.val   = din;
                st_next.ticks = '0;
            end else begin
                st_next.ticks = st_reg.ticks + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.val;

endmodule : hsdg_debounce

// [core/hsdg_tick_gen.sv]
// Millisecond tick generator for the debounce filters.
// Assumes one free running clock; tick period is a parameter for simulation.
`timescale 1ns/1ps
module hsdg_tick_gen #(
    parameter int TICK_CYCLES = hsdg_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Tick out
    output logic      ms_tick
);

    typedef struct packed {
        logic [hsdg_pkg::TICK_CNT_W-1:0] cnt;
        logic                            tick;
    } hsdg_tick_s;

    hsdg_tick_s st_reg;
    hsdg_tick_s st_next;

    // Count down one millisecond
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt == '0) begin
            st_next.cnt  = hsdg_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ms_tick = st_reg.tick;

endmodule : hsdg_tick_gen

// [pkg/hsdg_pkg.sv]
// Package for the headset detect and general pin control block.
// Assumes a 125 MHz core clock and a register port with word index addressing.
package hsdg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  HEADSET_DETECT_PIN_FUNCTION_OFS = 8'h22;
    localparam logic [7:0]  GENERAL_PIN_CONTROL_OFS         = 8'h23;

    // Field positions, function register
    localparam int DET_EN_BIT      = 15;
    localparam int KIND_LSB        = 13;
    localparam int PRESENT_BIT     = 12;
    localparam int BUTTON_BIT      = 11;
    localparam int HS_DEB_LSB      = 9;
    localparam int BTN_DEB_LSB     = 6;
    localparam int PIN_B_IRQ_BIT   = 4;
    localparam int PIN_A_IRQ_BIT   = 3;
    localparam int PIN_B_CLK_BIT   = 2;
    localparam int PIN_A_FUNC_LSB  = 0;

    // Field positions, pin control register
    localparam int PIN_B_OUT_EN_BIT  = 15;
    localparam int PIN_B_OUT_LVL_BIT = 14;
    localparam int PIN_B_IN_EN_BIT   = 13;
    localparam int PIN_B_IN_LVL_BIT  = 12;
    localparam int PIN_A_OUT_EN_BIT  = 11;
    localparam int PIN_A_OUT_LVL_BIT = 10;
    localparam int PIN_A_IN_EN_BIT   = 9;
    localparam int PIN_A_IN_LVL_BIT  = 8;

    // Reset values
    localparam logic [1:0] HS_DEB_RESET  = 2'h1;
    localparam logic [1:0] BTN_DEB_RESET = 2'h0;

    // Pin A function codes
    localparam logic [1:0] PIN_A_FUNC_BUTTON_IRQ = 2'h2;
    localparam logic [1:0] PIN_A_FUNC_ADC_WS     = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ   = 125_000_000;
    localparam int TICK_MS       = 1;
    localparam int TICK_CYCLES   = CLK_FREQ_HZ / 1000 * TICK_MS;
    localparam int DEB_TICKS     = 8;      // Duration is eight ticks at every setting except button debounce off
    localparam int TICK_CNT_W    = 17;
    localparam int MS_DIV_W      = 5;      // Up to 16 ms per tick
    localparam int FWD_MULT      = 256;

endpackage : hsdg_pkg

// [tb/hsdg_far_side.sv]
// Far side model: headset jack sense lines and host pins on the two general pins.
// Assumes the bench commands jack state and host levels; pins are resolved here.
`timescale 1ns/1ps
module hsdg_far_side (
    // Jack state and host pin levels from the bench
    input  wire logic stereo_cmd, cell_cmd, button_cmd, host_a_lvl, host_b_lvl,
    // Device pin drive
    input  wire logic pin_a_o, pin_a_oe, pin_b_o, pin_b_oe,
    // Lines into the device
    output logic      sense_stereo, sense_cellular, sense_button, pin_a_i, pin_b_i
);
    // Jack contacts follow the plugged headset
    assign sense_stereo   = stereo_cmd;
    assign sense_cellular = cell_cmd;
    assign sense_button   = button_cmd;
    // Host drives a pin only while the device has released it
    assign pin_a_i = pin_a_oe ? pin_a_o : host_a_lvl;
    assign pin_b_i = pin_b_oe ? pin_b_o : host_b_lvl;
endmodule : hsdg_far_side

// [tb/tb.sv]
// Testbench for the headset detect and general pin control block.
// Assumes a shortened tick of 4 cycles, so 1 ms of debounce is 4 clocks.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
    logic        clk, nrst, reg_wr, reg_rd, pll_enabled, fwd_clk_play, fwd_clk_rec;
    logic        play_rate_faster, adc_word_select, split_word_select;
    logic        sense_stereo, sense_cellular, sense_button, st, ce, bt, ha, hb;
    logic        general_pin_a_i, general_pin_a_o, general_pin_a_oe;
    logic        general_pin_b_i, general_pin_b_o, general_pin_b_oe;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    int          num_errors, num_checks;

    // -----------------------------------------------------------------
    // Clock, instances
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    hsdg_ctrl #(.TICK_CYCLES(4)) DUT (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .sense_stereo, .sense_cellular, .sense_button,
        .pll_enabled, .fwd_clk_play, .fwd_clk_rec, .play_rate_faster, .adc_word_select,
        .split_word_select, .general_pin_a_i, .general_pin_a_o, .general_pin_a_oe,
        .general_pin_b_i, .general_pin_b_o, .general_pin_b_oe);
    hsdg_far_side far (.stereo_cmd(st), .cell_cmd(ce), .button_cmd(bt),
        .host_a_lvl(ha), .host_b_lvl(hb), .pin_a_o(general_pin_a_o),
        .pin_a_oe(general_pin_a_oe), .pin_b_o(general_pin_b_o),
        .pin_b_oe(general_pin_b_oe), .sense_stereo, .sense_cellular, .sense_button,
        .pin_a_i(general_pin_a_i), .pin_b_i(general_pin_b_i));

    // -----------------------------------------------------------------
    // Register port tasks
    // -----------------------------------------------------------------
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task rdchk(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a; reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        cyc(1);
        `CHK(reg_rdata, e)
    endtask : rdchk
    task pins(input logic [3:0] e);
        cyc(3);
        `CHK({general_pin_a_oe, general_pin_a_o, general_pin_b_oe, general_pin_b_o}, e)
    endtask : pins
    task results;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Watchdog against a hang
    initial begin
        #200000;
        num_errors++;
        results();
    end

    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial begin
        {nrst, reg_wr, reg_rd, pll_enabled, fwd_clk_play, fwd_clk_rec} = 6'h0;
        {play_rate_faster, adc_word_select, st, ce, bt, ha, hb} = 7'h0;
        reg_addr = 8'h0; reg_wdata = 16'h0; num_errors = 0; num_checks = 0;
        cyc(10);
        nrst = 1'b1;
        rdchk(8'h22, 16'h0200);
        rdchk(8'h23, 16'h0000);
        rdchk(8'h30, 16'h0000);
        $display("test reset done");
        wr(8'h23, 16'hdd00);
        pins(4'hf);
        rdchk(8'h23, 16'hcc00);
        wr(8'h23, 16'h8800);
        pins(4'ha);
        ha = 1'b1;
        wr(8'h23, 16'h2200);
        pins(4'h0);
        rdchk(8'h23, 16'h2300);
        hb = 1'b1;
        rdchk(8'h23, 16'h3300);
        wr(8'h23, 16'h0000);
        $display("test general pins done");
        st = 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'h22, 16'h0000);
            wr(8'h22, 16'h8000 | (16'(s) << 9));
            cyc(40 << s);
            rdchk(8'h22, 16'h8000 | (16'(s) << 9));
            cyc(40 << s);
            rdchk(8'h22, 16'hb000 | (16'(s) << 9));
        end
        ce = 1'b1;
        cyc(100);
        ce = 1'b0;
        cyc(600);
        rdchk(8'h22, 16'hb600);
        wr(8'h22, 16'h8000);
        ce = 1'b1;
        cyc(90);
        rdchk(8'h22, 16'hf000);
        st = 1'b0;
        cyc(90);
        rdchk(8'h22, 16'hd000);
        bt = 1'b1;
        rdchk(8'h22, 16'hd800);
        for (int b = 1; b < 4; b++) begin
            wr(8'h22, 16'h8000 | (16'(b) << 6));
            bt = ~bt;
            cyc(12 << b);
            rdchk(8'h22, 16'hd000 | (16'(b) << 6) | (b[0] ? 16'h0800 : 16'h0000));
            cyc(12 << b);
            rdchk(8'h22, 16'hd000 | (16'(b) << 6) | (b[0] ? 16'h0000 : 16'h0800));
        end
        bt = 1'b1;
        $display("test detection done");
        wr(8'h22, 16'h8018);
        pins(4'hf);
        wr(8'h23, 16'h2200);
        pins(4'h0);
        wr(8'h23, 16'h0000);
        for (int f = 0; f < 4; f++) begin
            wr(8'h22, 16'h8000 | 16'(f));
            cyc(3);
            `CHK({general_pin_a_oe, general_pin_a_o, split_word_select}, {f[1], f == 2, f == 3})
        end
        adc_word_select = 1'b1;
        cyc(3);
        `CHK(general_pin_a_o, 1'b1)
        {pll_enabled, fwd_clk_play, play_rate_faster} = 3'h7;
        wr(8'h22, 16'h8004);
        pins(4'h3);
        play_rate_faster = 1'b0;
        pins(4'h2);
        wr(8'h22, 16'h8014);
        pins(4'h3);
        wr(8'h22, 16'h8004);
        pll_enabled = 1'b0;
        pins(4'h0);
        wr(8'h22, 16'h0000);
        rdchk(8'h22, 16'h0000);
        $display("test pin functions done");
        results();
    end
endmodule : tb
